/* fcs_pkg.sv */
// Package for the flash command host: command codes, addresses, timing and carrier types
package fcs_pkg;
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned AW              = 19;
  localparam logic [7:0]  CD_UNLOCK1      = 8'haa;
  localparam logic [7:0]  CD_UNLOCK2      = 8'h55;
  localparam logic [7:0]  CD_RESET        = 8'hf0;
  localparam logic [7:0]  CD_AUTOSEL      = 8'h90;
  localparam logic [7:0]  CD_PROGRAM      = 8'ha0;
  localparam logic [7:0]  CD_BYPASS       = 8'h20;
  localparam logic [7:0]  CD_BYP_EXIT     = 8'h00;
  localparam logic [7:0]  CD_ERASE_SETUP  = 8'h80;
  localparam logic [7:0]  CD_CHIP_ERASE   = 8'h10;
  localparam logic [7:0]  CD_BLOCK_ERASE  = 8'h30;
  localparam logic [7:0]  CD_SUSPEND      = 8'hb0;
  localparam logic [7:0]  CD_RESUME       = 8'h30;
  localparam logic [AW-1:0] AD_FIRST      = 19'h00aaa;
  localparam logic [AW-1:0] AD_SECOND     = 19'h00555;
  localparam logic [AW-1:0] AD_PROTECT_RD = 19'h00002;
  // Strobe timing: setup, low pulse, read access, in nanoseconds
  localparam int unsigned T_SETUP_NS      = 20;
  localparam int unsigned T_PULSE_NS      = 40;
  localparam int unsigned T_READ_NS       = 60;
  localparam int unsigned SETUP_CYC       = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PULSE_CYC       = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned READ_CYC        = (T_READ_NS * CLK_MHZ + 999) / 1000;
  // Block-add window of the erase controller (longest time, rounded down)
  localparam int unsigned T_BLOCK_WIN_US  = 50;
  localparam int unsigned BLOCK_WIN_CYC   = T_BLOCK_WIN_US * CLK_MHZ;
  localparam int unsigned CW              = 16;

  typedef enum logic [3:0] {
    FCS_OP_RESET     = 4'h0,
    FCS_OP_RESET3    = 4'h1,
    FCS_OP_AUTOSEL   = 4'h2,
    FCS_OP_PROGRAM   = 4'h3,
    FCS_OP_BYPASS    = 4'h4,
    FCS_OP_BYP_PROG  = 4'h5,
    FCS_OP_BYP_EXIT  = 4'h6,
    FCS_OP_CHIP_ERS  = 4'h7,
    FCS_OP_BLOCK_ERS = 4'h8,
    FCS_OP_SUSPEND   = 4'h9,
    FCS_OP_RESUME    = 4'ha,
    FCS_OP_READ      = 4'hb
  } fcs_op_t;

  typedef struct packed {
    fcs_op_t         op;
    logic [AW-1:0]   addr;
    logic [7:0]      data;
  } fcs_req_t;

  typedef struct packed {
    logic [AW-1:0]   addr;
    logic [7:0]      data;
  } fcs_cycle_t;
endpackage

/* fcs_host.sv */
// Host-side sequencer that drives flash commands as bus write cycles over byte-wide pins
`timescale 1ns/1ps
// Notes on behaviour
// - Command codes and addresses are issued exactly as the hexadecimal table gives.
// - Reset is one F0 write, or unlock pair then F0.
// - Auto select is unlock pair then 90 at AAA.
// - Program is unlock pair, A0 at AAA, then target address and value.
// - After an error, the caller requests reset to restore array reads.
// - Bypass entry is unlock pair then 20 at AAA.
// - Bypass program is A0 anywhere, then target address and value.
// - Bypass exit is 90 then 00 to any address.
// - Chip erase is six writes ending with 10 at AAA.
// - Block erase is chip-erase prefix then 30 at a block address.
// - Extra blocks must follow within the 50 us window.
// - Suspend is one B0 write to any address.
// - Resume is one 30 write to any address.
module fcs_host #(
  parameter int unsigned BLOCK_WIN_CYC = fcs_pkg::BLOCK_WIN_CYC
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  // Command request
  input  wire fcs_pkg::fcs_req_t          req,
  input  wire logic                       req_valid,
  output logic                            req_ready,
  output logic                            rsp_valid,
  output logic [7:0]                      rsp_data,
  output logic                            win_open,
  // Flash pins
  output logic [fcs_pkg::AW-1:0]          flash_addr,
  output logic [7:0]                      flash_dq_out,
  output logic                            flash_dq_oe,
  input  wire logic [7:0]                 flash_dq_in,
  output logic                            flash_ce_n,
  output logic                            flash_we_n,
  output logic                            flash_oe_n
);
  typedef enum logic [4:0] {
    FCS_IDLE  = 5'b00001,
    FCS_SETUP = 5'b00010,
    FCS_PULSE = 5'b00100,
    FCS_HOLD  = 5'b01000,
    FCS_READ  = 5'b10000
  } fcs_state_t;

  localparam logic [15:0] SETUP_N = 16'(fcs_pkg::SETUP_CYC);
  localparam logic [15:0] PULSE_N = 16'(fcs_pkg::PULSE_CYC);
  localparam logic [15:0] READ_N  = 16'(fcs_pkg::READ_CYC);
  localparam logic [31:0] WIN_N   = 32'(BLOCK_WIN_CYC);

  fcs_state_t                 state_q, state_d;
  fcs_pkg::fcs_cycle_t        seq_q [6];
  fcs_pkg::fcs_cycle_t        seq_d [6];
  logic [2:0]                 len_q, len_d, idx_q, idx_d;
  logic [15:0]                cnt_q, cnt_d;
  logic [31:0]                win_q, win_d;
  logic                       is_blk_q, is_blk_d;
  logic                       ready_q, ready_d, rv_q, rv_d;
  logic [7:0]                 rdat_q, rdat_d;
  logic [fcs_pkg::AW-1:0]     addr_q, addr_d;
  logic [7:0]                 dq_q, dq_d;
  logic                       oe_q, oe_d, ce_q, ce_d, we_q, we_d, rd_q, rd_d;

  // Unlocked command prefix: cycles 0-1 unlock, cycle 2 code at AAA, or F0 at 0 for reset
  function automatic fcs_pkg::fcs_cycle_t cyc(input logic [fcs_pkg::AW-1:0] a, input logic [7:0] d);
    fcs_pkg::fcs_cycle_t c;
    c.addr = a;
    c.data = d;
    return c;
  endfunction

  always_comb begin
    state_d  = state_q;
    seq_d    = seq_q;
    len_d    = len_q;
    idx_d    = idx_q;
    cnt_d    = cnt_q;
    win_d    = (win_q != 32'h0) ? win_q - 32'h1 : 32'h0;
    is_blk_d = is_blk_q;
    ready_d  = ready_q;
    rv_d     = 1'b0;
    rdat_d   = rdat_q;
    addr_d   = addr_q;
    dq_d     = dq_q;
    oe_d     = oe_q;
    ce_d     = ce_q;
    we_d     = we_q;
    rd_d     = rd_q;
    case (state_q)
      FCS_IDLE: begin
        if (req_valid && ready_q) begin
          ready_d  = 1'b0;
          idx_d    = 3'd0;
          is_blk_d = 1'b0;
          seq_d[0] = cyc(fcs_pkg::AD_FIRST, fcs_pkg::CD_UNLOCK1);
          seq_d[1] = cyc(fcs_pkg::AD_SECOND, fcs_pkg::CD_UNLOCK2);
          seq_d[3] = cyc(fcs_pkg::AD_FIRST, fcs_pkg::CD_UNLOCK1);
          seq_d[4] = cyc(fcs_pkg::AD_SECOND, fcs_pkg::CD_UNLOCK2);
          // Upper address bits are don't-care to the decoder; pass the caller's value for targets only
          case (req.op)
            fcs_pkg::FCS_OP_RESET: begin
              seq_d[0] = cyc('0, fcs_pkg::CD_RESET);
              len_d    = 3'd1;
            end
            fcs_pkg::FCS_OP_RESET3: begin
              seq_d[2] = cyc('0, fcs_pkg::CD_RESET);
              len_d    = 3'd3;
            end
            fcs_pkg::FCS_OP_AUTOSEL: begin
              seq_d[2] = cyc(fcs_pkg::AD_FIRST, fcs_pkg::CD_AUTOSEL);
              len_d    = 3'd3;
            end
            fcs_pkg::FCS_OP_PROGRAM: begin
              seq_d[2] = cyc(fcs_pkg::AD_FIRST, fcs_pkg::CD_PROGRAM);
              seq_d[3] = cyc(req.addr, req.data);
              len_d    = 3'd4;
            end
            fcs_pkg::FCS_OP_BYPASS: begin
              seq_d[2] = cyc(fcs_pkg::AD_FIRST, fcs_pkg::CD_BYPASS);
              len_d    = 3'd3;
            end
            fcs_pkg::FCS_OP_BYP_PROG: begin
              seq_d[0] = cyc('0, fcs_pkg::CD_PROGRAM);
              seq_d[1] = cyc(req.addr, req.data);
              len_d    = 3'd2;
            end
            fcs_pkg::FCS_OP_BYP_EXIT: begin
              seq_d[0] = cyc('0, fcs_pkg::CD_AUTOSEL);
              seq_d[1] = cyc('0, fcs_pkg::CD_BYP_EXIT);
              len_d    = 3'd2;
            end
            fcs_pkg::FCS_OP_CHIP_ERS: begin
              seq_d[2] = cyc(fcs_pkg::AD_FIRST, fcs_pkg::CD_ERASE_SETUP);
              seq_d[5] = cyc(fcs_pkg::AD_FIRST, fcs_pkg::CD_CHIP_ERASE);
              len_d    = 3'd6;
            end
            fcs_pkg::FCS_OP_BLOCK_ERS: begin
              is_blk_d = 1'b1;
              if (win_q != 32'h0) begin
                // Window still open: only the block-select write is repeated
                seq_d[0] = cyc(req.addr, fcs_pkg::CD_BLOCK_ERASE);
                len_d    = 3'd1;
              end else begin
                seq_d[2] = cyc(fcs_pkg::AD_FIRST, fcs_pkg::CD_ERASE_SETUP);
                seq_d[5] = cyc(req.addr, fcs_pkg::CD_BLOCK_ERASE);
                len_d    = 3'd6;
              end
            end
            fcs_pkg::FCS_OP_SUSPEND: begin
              seq_d[0] = cyc('0, fcs_pkg::CD_SUSPEND);
              len_d    = 3'd1;
            end
            fcs_pkg::FCS_OP_RESUME: begin
              seq_d[0] = cyc('0, fcs_pkg::CD_RESUME);
              len_d    = 3'd1;
            end
            default: begin
              // Plain read; protection status also uses the caller's address unchanged
              seq_d[0] = cyc(req.addr, 8'h00);
              len_d    = 3'd0;
            end
          endcase
          addr_d = (req.op == fcs_pkg::FCS_OP_READ) ? req.addr : addr_q;
          ce_d   = 1'b0;
          cnt_d  = (req.op == fcs_pkg::FCS_OP_READ) ? READ_N : SETUP_N;
          state_d = (req.op == fcs_pkg::FCS_OP_READ) ? FCS_READ : FCS_SETUP;
          oe_d   = 1'b0;
          // Held active low so the output enable pin comes straight from this flop
          rd_d   = (req.op != fcs_pkg::FCS_OP_READ);
        end
      end
      FCS_SETUP: begin
        // Command addresses carry zero upper bits; targets keep the caller's full address
        addr_d = seq_q[idx_q].addr;
        dq_d = seq_q[idx_q].data;
        oe_d = 1'b1;
        if (cnt_q <= 16'd1) begin
          we_d    = 1'b0;
          cnt_d   = PULSE_N;
          state_d = FCS_PULSE;
        end else begin
          cnt_d = cnt_q - 16'd1;
        end
      end
      FCS_PULSE: begin
        if (cnt_q <= 16'd1) begin
          we_d    = 1'b1; // Rising edge latches the data
          cnt_d   = SETUP_N;
          state_d = FCS_HOLD;
        end else begin
          cnt_d = cnt_q - 16'd1;
        end
      end
      FCS_HOLD: begin
        if (cnt_q <= 16'd1) begin
          if (idx_q + 3'd1 >= len_q) begin
            ce_d    = 1'b1;
            oe_d    = 1'b0;
            ready_d = 1'b1;
            rv_d    = 1'b1;
            if (is_blk_q) begin
              win_d = WIN_N;
            end
            state_d = FCS_IDLE;
          end else begin
            idx_d   = idx_q + 3'd1;
            cnt_d   = SETUP_N;
            state_d = FCS_SETUP;
          end
        end else begin
          cnt_d = cnt_q - 16'd1;
        end
      end
      FCS_READ: begin
        // Reads during busy time return status; the caller polls it
        if (cnt_q <= 16'd1) begin
          rdat_d  = flash_dq_in;
          rv_d    = 1'b1;
          ce_d    = 1'b1;
          rd_d    = 1'b1;
          ready_d = 1'b1;
          state_d = FCS_IDLE;
        end else begin
          cnt_d = cnt_q - 16'd1;
        end
      end
      default: state_d = FCS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q  <= FCS_IDLE;
      for (int i = 0; i < 6; i++) seq_q[i] <= '0;
      len_q    <= 3'd0;
      idx_q    <= 3'd0;
      cnt_q    <= 16'h0000;
      win_q    <= 32'h0000_0000;
      is_blk_q <= 1'b0;
      ready_q  <= 1'b1;
      rv_q     <= 1'b0;
      rdat_q   <= 8'h00;
      addr_q   <= '0;
      dq_q     <= 8'h00;
      oe_q     <= 1'b0;
      ce_q     <= 1'b1;
      we_q     <= 1'b1;
      rd_q     <= 1'b1;
    end else begin
      state_q  <= state_d;
      seq_q    <= seq_d;
      len_q    <= len_d;
      idx_q    <= idx_d;
      cnt_q    <= cnt_d;
      win_q    <= win_d;
      is_blk_q <= is_blk_d;
      ready_q  <= ready_d;
      rv_q     <= rv_d;
      rdat_q   <= rdat_d;
      addr_q   <= addr_d;
      dq_q     <= dq_d;
      oe_q     <= oe_d;
      ce_q     <= ce_d;
      we_q     <= we_d;
      rd_q     <= rd_d;
    end
  end

  logic win_open_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      win_open_q <= 1'b0;
    end else begin
      win_open_q <= (win_d != 32'h0);
    end
  end

  assign req_ready    = ready_q;
  assign rsp_valid    = rv_q;
  assign rsp_data     = rdat_q;
  assign win_open     = win_open_q;
  assign flash_addr   = addr_q;
  assign flash_dq_out = dq_q;
  assign flash_dq_oe  = oe_q;
  assign flash_ce_n   = ce_q;
  assign flash_we_n   = we_q;
  assign flash_oe_n   = rd_q;
endmodule // fcs_host

/* fcs_host_props.sv */
// Checker for the flash command host strobes and request handshake
`timescale 1ns/1ps
module fcs_host_props #(
  parameter int unsigned BLOCK_WIN_CYC = fcs_pkg::BLOCK_WIN_CYC
) (
  // Clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  // Requests
  input wire fcs_pkg::fcs_req_t      req,
  input wire logic                   req_valid,
  input wire logic                   req_ready,
  input wire logic                   rsp_valid,
  // Flash pins
  input wire logic [fcs_pkg::AW-1:0] flash_addr,
  input wire logic [7:0]             flash_dq_out,
  input wire logic                   flash_dq_oe,
  input wire logic                   flash_ce_n,
  input wire logic                   flash_we_n,
  input wire logic                   flash_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  we_pulse_len_a: assert property ($fell(flash_we_n) |-> (!flash_we_n)[*8] ##1 (!flash_we_n)[*2] ##1 flash_we_n)
    else $error("write strobe width wrong");
  we_frame_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
    else $error("write strobe outside a driven select");
  we_stable_a: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved under write strobe");
  we_rise_hold_a: assert property ($rose(flash_we_n) |-> !flash_ce_n && flash_dq_oe && $stable(flash_dq_out))
    else $error("data released at strobe end");
  read_no_drive_a: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n && !flash_ce_n)
    else $error("host drives data during read");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  ready_drop_a: assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready held after request taken");
  read_lat_a: assert property (req_valid && req_ready && req.op == fcs_pkg::FCS_OP_READ |-> ##16 rsp_valid)
    else $error("read answer late or early");
endmodule // fcs_host_props

bind fcs_host fcs_host_props #(.BLOCK_WIN_CYC(BLOCK_WIN_CYC)) u_fcs_host_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .req(req), .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
  .flash_oe_n(flash_oe_n));

/* fcs_flash_model.sv */
// Behavioural byte-wide flash device: command decoder, small array and write log
`timescale 1ns/1ps
module fcs_flash_model (
  // Strobes and address
  input  wire logic [18:0] addr,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  // Data pins
  input  wire logic [7:0]  dq_out,
  output logic [7:0]       dq_in
);
  logic [18:0] wa[$];
  logic [7:0]  wd[$];
  logic [7:0]  mem[0:255];
  logic [7:0]  last_q = 8'h00;
  logic [2:0]  seq = 3'h0;
  logic        byp = 1'b0;

  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
  end

  // Only byte-address bits 11:0 and the data byte take part in decoding
  always @(posedge we_n) begin
    if (!ce_n) begin
      wa.push_back(addr);
      wd.push_back(dq_out);
      if (seq == 3'h4) begin
        mem[addr[7:0]] = mem[addr[7:0]] & dq_out;
        seq = 3'h0;
      end else if (dq_out == 8'hf0) seq = 3'h0;
      else if (seq == 3'h6 && dq_out == 8'h00) begin
        byp = 1'b0;
        seq = 3'h0;
      end else if (byp && dq_out == 8'ha0) seq = 3'h4;
      else if (byp && dq_out == 8'h90) seq = 3'h6;
      else if (!byp && seq == 3'h0 && addr[11:0] == 12'haaa && dq_out == 8'haa) seq = 3'h1;
      else if (seq == 3'h1 && addr[11:0] == 12'h555 && dq_out == 8'h55) seq = 3'h2;
      else if (seq == 3'h2 && addr[11:0] == 12'haaa && dq_out == 8'ha0) seq = 3'h4;
      else if (seq == 3'h2 && addr[11:0] == 12'haaa && dq_out == 8'h20) begin
        byp = 1'b1;
        seq = 3'h0;
      end else seq = 3'h0;
    end
  end

  // A released bus shows the inverse of the last byte, so a stale sample cannot match
  always @* begin
    if (!ce_n && !oe_n) last_q = mem[addr[7:0]];
  end
  assign dq_in = (!ce_n && !oe_n) ? mem[addr[7:0]] : ~last_q;
endmodule // fcs_flash_model

/* fcs_host_tb_top.sv */
// Self-checking bench for the flash command host against the behavioural device
`timescale 1ns/1ps
module fcs_host_tb_top;
  localparam int unsigned WIN = 50;
  localparam logic [18:0] XA  = 19'h7ffff;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  fcs_pkg::fcs_req_t req = '0;
  logic              req_valid = 1'b0;
  logic              req_ready, rsp_valid, win_open, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  logic [7:0]        rsp_data, flash_dq_out, flash_dq_in;
  logic [18:0]       flash_addr;
  logic [18:0]       ea[$];
  logic [7:0]        ed[$];
  int                err_total = 0;
  int                samples_checked = 0;

  always #2 ref_clk = ~ref_clk;

  fcs_host #(.BLOCK_WIN_CYC(WIN)) u_fcs_host (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .win_open(win_open), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
  fcs_flash_model u_fcs_flash_model (.addr(flash_addr), .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
    .dq_out(flash_dq_out), .dq_in(flash_dq_in));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [18:0] e, input logic [18:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Entered one step after an edge; returns in the response cycle
  task automatic do_op(input fcs_pkg::fcs_op_t op, input logic [18:0] a, input logic [7:0] d);
    int n;
    req = '{op: op, addr: a, data: d};
    req_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 400) begin
        chk("rsp_valid", 19'h1, 19'h0);
        report_and_stop();
      end
    end
  endtask

  function automatic void pw(input logic [18:0] a, input logic [7:0] d);
    ea.push_back(a);
    ed.push_back(d);
  endfunction

  // Expected writes: unlock pair if u > 0, optional middle write, second unlock pair if u > 1, final write
  task automatic run_chk(input fcs_pkg::fcs_op_t op, input logic [18:0] a, input logic [7:0] d, input int u,
                         input logic m, input logic [18:0] ma, input logic [7:0] md, input logic [18:0] fa,
                         input logic [7:0] fd);
    ea = {};
    ed = {};
    if (u > 0) pw(19'h00aaa, 8'haa);
    if (u > 0) pw(19'h00555, 8'h55);
    if (m) pw(ma, md);
    if (u > 1) pw(19'h00aaa, 8'haa);
    if (u > 1) pw(19'h00555, 8'h55);
    pw(fa, fd);
    u_fcs_flash_model.wa = {};
    u_fcs_flash_model.wd = {};
    do_op(op, a, d);
    chk("write_count", 19'(ea.size()), 19'(u_fcs_flash_model.wa.size()));
    foreach (ea[i]) begin
      if (i < u_fcs_flash_model.wa.size()) begin
        if (ea[i] != XA) chk("write_addr", ea[i], u_fcs_flash_model.wa[i]);
        chk("write_data", 19'(ed[i]), 19'(u_fcs_flash_model.wd[i]));
      end
    end
  endtask

  task automatic rd_chk(input logic [18:0] a, input logic [7:0] e);
    do_op(fcs_pkg::FCS_OP_READ, a, 8'h00);
    chk("read_data", 19'(e), 19'(rsp_data));
  endtask

  task automatic t_cmd_table();
    run_chk(fcs_pkg::FCS_OP_RESET, '0, '0, 0, 0, '0, '0, XA, 8'hf0);
    run_chk(fcs_pkg::FCS_OP_RESET3, '0, '0, 1, 0, '0, '0, XA, 8'hf0);
    run_chk(fcs_pkg::FCS_OP_AUTOSEL, '0, '0, 1, 0, '0, '0, 19'h00aaa, 8'h90);
    run_chk(fcs_pkg::FCS_OP_BYPASS, '0, '0, 1, 0, '0, '0, 19'h00aaa, 8'h20);
    run_chk(fcs_pkg::FCS_OP_BYP_PROG, 19'h00020, 8'h5a, 0, 1, XA, 8'ha0, 19'h00020, 8'h5a);
    rd_chk(19'h00020, 8'h5a);
    run_chk(fcs_pkg::FCS_OP_BYP_EXIT, '0, '0, 0, 1, XA, 8'h90, XA, 8'h00);
    run_chk(fcs_pkg::FCS_OP_CHIP_ERS, '0, '0, 2, 1, 19'h00aaa, 8'h80, 19'h00aaa, 8'h10);
    run_chk(fcs_pkg::FCS_OP_SUSPEND, '0, '0, 0, 0, '0, '0, XA, 8'hb0);
    run_chk(fcs_pkg::FCS_OP_RESUME, '0, '0, 0, 0, '0, '0, XA, 8'h30);
    $display("t_cmd_table done");
  endtask

  task automatic t_program();
    run_chk(fcs_pkg::FCS_OP_PROGRAM, 19'h00010, 8'h3c, 1, 1, 19'h00aaa, 8'ha0, 19'h00010, 8'h3c);
    rd_chk(19'h00010, 8'h3c);
    run_chk(fcs_pkg::FCS_OP_PROGRAM, 19'h00010, 8'hc3, 1, 1, 19'h00aaa, 8'ha0, 19'h00010, 8'hc3);
    rd_chk(19'h00010, 8'h00);
    $display("t_program done");
  endtask

  task automatic t_window();
    int n;
    run_chk(fcs_pkg::FCS_OP_BLOCK_ERS, 19'h10000, 8'h30, 2, 1, 19'h00aaa, 8'h80, 19'h10000, 8'h30);
    chk("win_open", 19'h1, 19'(win_open));
    run_chk(fcs_pkg::FCS_OP_BLOCK_ERS, 19'h20000, 8'h30, 0, 0, '0, '0, 19'h20000, 8'h30);
    n = 0;
    while (win_open === 1'b1 && n < WIN + 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("win_len_ok", 19'h1, 19'(n >= WIN - 25 && n <= WIN + 2));
    run_chk(fcs_pkg::FCS_OP_BLOCK_ERS, 19'h30000, 8'h30, 2, 1, 19'h00aaa, 8'h80, 19'h30000, 8'h30);
    $display("t_window done");
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_cmd_table();
    t_program();
    t_window();
    report_and_stop();
  end
endmodule // fcs_host_tb_top
